/* File: adc_out_pkg.sv */
// adc_out_pkg: constants, field layouts and carrier types for the converter output block.
// assumes a single 100 MHz system clock; sample clocks arrive as one-cycle enable pulses.
package adc_out_pkg;

    // ------------------------------------------------------------
    // code format
    // ------------------------------------------------------------
    localparam int SAMPLE_W = 10;
    localparam int RAW_W = 12;
    localparam logic [SAMPLE_W-1:0] CODE_MID = 10'h200;
    localparam logic [SAMPLE_W-1:0] CODE_MAX = 10'h3ff;
    localparam logic [SAMPLE_W-1:0] CODE_MIN = 10'h000;
    localparam logic signed [RAW_W-1:0] RAW_POS_LIMIT = 12'sh1ff;
    localparam logic signed [RAW_W-1:0] RAW_NEG_LIMIT = -12'sh200;
    // one output step in the 2 V range, in microvolts
    localparam int LSB_STEP_UV = 1953;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 100;
    localparam int NAP_RECOVER_SAMPLES = 100;
    localparam int DCS_RELOCK_SAMPLES = 100;
    localparam int SLEEP_RECOVER_US = 2000;
    localparam int SLEEP_RECOVER_CYC = SLEEP_RECOVER_US * CLK_FREQ_MHZ;
    localparam int CLK_STOP_NS = 2000;
    localparam int CLK_STOP_CYC = (CLK_STOP_NS * CLK_FREQ_MHZ) / 1000;

    // ------------------------------------------------------------
    // register map and fields
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h0c;
    localparam int CTRL_OVR_EN = 0;
    localparam int CTRL_OVR_LVL = 1;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam int IRQ_OVER = 0;
    localparam int IRQ_READY = 1;
    localparam int IRQ_PWRDN = 2;
    localparam int IRQ_W = 3;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {STRAP_GND, STRAP_THIRD, STRAP_TWO_THIRD, STRAP_VDD} strap_level_e;
    typedef enum logic [1:0] {PWR_RUN, PWR_NAP, PWR_SLEEP, PWR_RECOVER} pwr_state_e;

    typedef struct packed {
        logic over_range;
        logic [SAMPLE_W-1:0] bits;
    } sample_word_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

endpackage

/* File: pin_sync.sv */
// pin_sync: two-flop synchroniser for a group of slow level inputs.
// assumes the inputs are quasi-static levels from outside the clock domain.
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    // ------------------------------------------------------------
    // first flop feeds only the second one
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_r <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

/* File: code_formatter.sv */
// code_formatter: clamps a signed conversion result and maps it to the output code.
// assumes the result is signed LSB counts around zero differential input.
`timescale 1ns/1ps
module code_formatter (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // conversion input
    input wire logic sample_en,
    input wire logic twos_comp,
    input wire logic signed [adc_out_pkg::RAW_W-1:0] conv_value,
    // formatted word
    output adc_out_pkg::sample_word_s word
);
    import adc_out_pkg::*;

    // ------------------------------------------------------------
    // saturation and format
    // ------------------------------------------------------------
    wire over_pos = conv_value > RAW_POS_LIMIT;
    wire over_neg = conv_value < RAW_NEG_LIMIT;
    wire [RAW_W-1:0] shifted = RAW_W'(conv_value + RAW_W'(CODE_MID));
    // beyond either limit the code saturates at full scale
    wire [SAMPLE_W-1:0] offset_code = over_pos ? CODE_MAX :
                                      over_neg ? CODE_MIN : shifted[SAMPLE_W-1:0];
    // two's complement is offset binary with the top bit turned over
    wire [SAMPLE_W-1:0] fmt_code = twos_comp
                                 ? {~offset_code[SAMPLE_W-1], offset_code[SAMPLE_W-2:0]}
                                 : offset_code;

    // word only moves on a sample, so it holds between conversions
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            word <= '0;
        else if (sample_en)
            word <= '{over_range: over_pos | over_neg, bits: fmt_code};
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_midscale_offset: assert property (@(posedge clk) disable iff (!resetn)
        sample_en && !twos_comp && conv_value == 0 |=> word.bits == CODE_MID)
        else $error("zero input did not give midscale offset code");
    a_twos_msb_flip: assert property (@(posedge clk) disable iff (!resetn)
        sample_en && twos_comp && conv_value == RAW_NEG_LIMIT |=> word.bits == 10'h200)
        else $error("negative full scale wrong in two's complement");
    a_over_range_sat: assert property (@(posedge clk) disable iff (!resetn)
        sample_en && !twos_comp && over_pos |=> word.over_range && word.bits == CODE_MAX)
        else $error("positive overrange did not saturate and flag");
    a_in_range_clear: assert property (@(posedge clk) disable iff (!resetn)
        sample_en && !over_pos && !over_neg |=> !word.over_range)
        else $error("flag set for an in-range sample");

endmodule

/* File: adc_output_ctrl.sv */
// adc_output_ctrl: output format, overrange flag, tri-state and power modes of the converter.
// assumes sample_en pulses once per sample clock and conv_value is valid beside it;
// strap and control pins are asynchronous levels, registers use a plain strobe port.
//
// Behaviour
// - offset binary: zero input gives midscale, full scales give all ones and zeros
// - two's complement output is offset binary with its top bit inverted
// - overrange flag high beyond either limit, code saturates at full scale
// - one output step equals about 1.953 mV in the 2 V range
// - strap at ground or one third selects offset binary
// - strap at two thirds or full selects two's complement; stabilizer at middle levels
// - output disable high puts sample bits and flag in high impedance
// - shutdown low means normal operation, one result per sample clock
// - shutdown and disable high enter sleep; data invalid for milliseconds after exit
// - shutdown high, disable low enter nap; data valid about 100 clocks after exit
// - sleep and nap hold sample bits and flag in high impedance
// - stabilizer samples on rising edge only and makes its own half period
// - after a long clock stop the stabilizer needs about 100 clocks to relock
`timescale 1ns/1ps
module adc_output_ctrl #(
    parameter int SLEEP_RECOVER_CLKS = adc_out_pkg::SLEEP_RECOVER_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // converter core
    input wire logic sample_en,
    input wire logic signed [adc_out_pkg::RAW_W-1:0] conv_value,
    // control pins
    input wire logic [1:0] format_strap,
    input wire logic out_disable,
    input wire logic power_down_select,
    // register port
    input wire adc_out_pkg::reg_req_s reg_req,
    output logic [31:0] reg_rdata,
    // output pins
    output logic [adc_out_pkg::SAMPLE_W-1:0] sample_bits,
    output logic over_range_flag,
    output logic data_oe_n,
    output logic data_valid,
    // power and clock control
    output logic dcs_enable,
    output logic core_power_down,
    output logic ref_power_down,
    // interrupt
    output logic irq
);
    import adc_out_pkg::*;

    localparam int REC_W = $clog2(SLEEP_RECOVER_CLKS + 1);
    localparam int IDLE_W = $clog2(CLK_STOP_CYC + 1);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    generate
        if (SLEEP_RECOVER_CLKS < NAP_RECOVER_SAMPLES)
        begin : g_bad_param
            $error("sleep recovery must not be shorter than nap recovery");
        end
    endgenerate

    // ------------------------------------------------------------
    // pin synchronisation and strap capture
    // ------------------------------------------------------------
    logic [3:0] pins_s;
    wire [1:0] strap_s = pins_s[3:2];
    wire disable_s = pins_s[1];
    wire pwr_dn_s = pins_s[0];

    pin_sync #(.WIDTH(4)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in({format_strap, out_disable, power_down_select}),
        .sync_out(pins_s)
    );

    logic [1:0] strap_lvl_r;
    logic [2:0] strap_wait_r;
    logic [2:0] ctrl_r;
    // the strap is caught once the synchroniser has filled after reset release
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            strap_wait_r <= 3'h0;
            strap_lvl_r <= 2'h0;
        end
        else if (!strap_wait_r[2])
        begin
            strap_wait_r <= strap_wait_r + 3'h1;
            strap_lvl_r <= strap_s;
        end
    end

    // software may override the strap level for bring-up
    wire [1:0] level = ctrl_r[CTRL_OVR_EN] ? ctrl_r[CTRL_OVR_LVL +: 2] : strap_lvl_r;
    wire twos_sel = (level == STRAP_TWO_THIRD) || (level == STRAP_VDD);
    wire dcs_sel = (level == STRAP_THIRD) || (level == STRAP_TWO_THIRD);

    // ------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------
    pwr_state_e state_r, state_nxt;
    logic [REC_W-1:0] rec_cnt_r;
    logic rec_by_samples_r;
    wire powered_down = (state_r == PWR_NAP) || (state_r == PWR_SLEEP);
    wire rec_done = (state_r == PWR_RECOVER) && (rec_cnt_r == '0);
    wire going_down = (state_nxt == PWR_NAP) || (state_nxt == PWR_SLEEP);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            PWR_RUN, PWR_RECOVER:
            begin
                if (pwr_dn_s)
                    state_nxt = disable_s ? PWR_SLEEP : PWR_NAP;
                else if (rec_done)
                    state_nxt = PWR_RUN;
            end
            PWR_NAP, PWR_SLEEP:
            begin
                if (!pwr_dn_s)
                    state_nxt = PWR_RECOVER;
                else
                    state_nxt = disable_s ? PWR_SLEEP : PWR_NAP;
            end
            default: state_nxt = PWR_RUN;
        endcase
    end

    // nap recovery counts sample clocks; sleep waits for the reference in real time
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= PWR_RUN;
            rec_cnt_r <= '0;
            rec_by_samples_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_r == PWR_NAP && !pwr_dn_s)
            begin
                rec_cnt_r <= REC_W'(NAP_RECOVER_SAMPLES);
                rec_by_samples_r <= 1'b1;
            end
            else if (state_r == PWR_SLEEP && !pwr_dn_s)
            begin
                rec_cnt_r <= REC_W'(SLEEP_RECOVER_CLKS);
                rec_by_samples_r <= 1'b0;
            end
            else if (state_r == PWR_RECOVER && rec_cnt_r != '0 && (sample_en || !rec_by_samples_r))
                rec_cnt_r <= rec_cnt_r - REC_W'(1);
        end
    end

    // ------------------------------------------------------------
    // stabilizer relock after a stopped clock
    // ------------------------------------------------------------
    logic [IDLE_W-1:0] idle_cnt_r;
    logic [6:0] relock_cnt_r;
    wire clock_stopped = (idle_cnt_r == IDLE_W'(CLK_STOP_CYC));

    // the relock wait only applies while the stabilizer is in use
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            idle_cnt_r <= '0;
            relock_cnt_r <= 7'h00;
        end
        else
        begin
            if (sample_en)
                idle_cnt_r <= '0;
            else if (!clock_stopped)
                idle_cnt_r <= idle_cnt_r + IDLE_W'(1);
            if (!dcs_sel)
                relock_cnt_r <= 7'h00;
            else if (clock_stopped && sample_en)
                relock_cnt_r <= 7'(DCS_RELOCK_SAMPLES);
            else if (sample_en && relock_cnt_r != 7'h00)
                relock_cnt_r <= relock_cnt_r - 7'h01;
        end
    end

    // ------------------------------------------------------------
    // output word and drivers
    // ------------------------------------------------------------
    sample_word_s word;
    wire convert_en = sample_en && !powered_down;
    wire word_good = (state_r == PWR_RUN) && (relock_cnt_r == 7'h00) && !clock_stopped;

    code_formatter u_fmt (
        .clk(clk),
        .resetn(resetn),
        .sample_en(convert_en),
        .twos_comp(twos_sel),
        .conv_value(conv_value),
        .word(word)
    );

    assign sample_bits = word.bits;
    assign over_range_flag = word.over_range;

    // drivers release in either power-down mode or on request
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            data_oe_n <= 1'b1;
            data_valid <= 1'b0;
            dcs_enable <= 1'b0;
            core_power_down <= 1'b0;
            ref_power_down <= 1'b0;
        end
        else
        begin
            data_oe_n <= disable_s || going_down;
            data_valid <= convert_en && word_good;
            dcs_enable <= dcs_sel;
            core_power_down <= going_down;
            ref_power_down <= (state_nxt == PWR_SLEEP);
        end
    end

    // ------------------------------------------------------------
    // registers and interrupt
    // ------------------------------------------------------------
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    wire wr_ctrl = reg_req.wr && (reg_req.addr == REG_CTRL);
    wire wr_stat = reg_req.wr && (reg_req.addr == REG_IRQ_STAT);
    wire wr_mask = reg_req.wr && (reg_req.addr == REG_IRQ_MASK);
    wire [IRQ_W-1:0] irq_events = {!powered_down && going_down,
                                   rec_done && !pwr_dn_s,
                                   convert_en && (conv_value > RAW_POS_LIMIT
                                       || conv_value < RAW_NEG_LIMIT)};
    wire [IRQ_W-1:0] stat_clr = wr_stat ? reg_req.wdata[IRQ_W-1:0] : '0;
    wire [31:0] status_word = {25'h0, relock_cnt_r != 7'h00, dcs_sel, twos_sel, level,
                               state_r};
    wire [31:0] rd_mux = (reg_req.addr == REG_CTRL) ? {29'h0, ctrl_r} :
                         (reg_req.addr == REG_STATUS) ? status_word :
                         (reg_req.addr == REG_IRQ_STAT) ? {29'h0, irq_stat_r} :
                         (reg_req.addr == REG_IRQ_MASK) ? {29'h0, irq_mask_r} : 32'h0000_0000;

    // a new event in the clearing cycle stays set
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_r <= CTRL_RESET;
            irq_mask_r <= IRQ_MASK_RESET;
            irq_stat_r <= '0;
            reg_rdata <= 32'h0000_0000;
            irq <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_r <= reg_req.wdata[2:0];
            if (wr_mask)
                irq_mask_r <= reg_req.wdata[IRQ_W-1:0];
            irq_stat_r <= (irq_stat_r & ~stat_clr) | irq_events;
            reg_rdata <= reg_req.rd ? rd_mux : 32'h0000_0000;
            irq <= |(((irq_stat_r & ~stat_clr) | irq_events) & irq_mask_r);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_disable_hiz: assert property (@(posedge clk) disable iff (!resetn)
        disable_s |=> data_oe_n)
        else $error("outputs driven while disable is high");
    a_powerdown_hiz: assert property (@(posedge clk) disable iff (!resetn)
        powered_down |-> data_oe_n)
        else $error("outputs driven in sleep or nap");
    a_sleep_entry: assert property (@(posedge clk) disable iff (!resetn)
        pwr_dn_s && disable_s |=> state_r == PWR_SLEEP && ref_power_down)
        else $error("sleep not entered");
    a_nap_entry: assert property (@(posedge clk) disable iff (!resetn)
        pwr_dn_s && !disable_s |=> state_r == PWR_NAP && !ref_power_down)
        else $error("nap not entered with reference alive");
    a_nap_no_data: assert property (@(posedge clk) disable iff (!resetn)
        state_r == PWR_NAP && !pwr_dn_s |=> (!data_valid) [*8])
        else $error("data valid too soon after nap");
    a_run_data_valid: assert property (@(posedge clk) disable iff (!resetn)
        sample_en && word_good |=> data_valid)
        else $error("sample in normal run not marked valid");
    a_format_select: assert property (@(posedge clk) disable iff (!resetn)
        sample_en && !powered_down && conv_value == 0
        |=> sample_bits == ($past(twos_sel) ? 10'h000 : CODE_MID))
        else $error("format does not follow strap level");
    a_relock_wait: assert property (@(posedge clk) disable iff (!resetn)
        clock_stopped && sample_en && dcs_sel
        |=> relock_cnt_r == 7'(DCS_RELOCK_SAMPLES) && !data_valid)
        else $error("stabilizer relock wait not started");
    a_irq_level: assert property (@(posedge clk) disable iff (!resetn)
        |(irq_stat_r & irq_mask_r) && !wr_stat |=> irq)
        else $error("unmasked status without interrupt");

    c_nap_cycle: cover property (@(posedge clk) disable iff (!resetn)
        state_r == PWR_NAP ##[1:600] rec_done);
    c_sleep_entry: cover property (@(posedge clk) disable iff (!resetn) state_r == PWR_SLEEP);
    c_overrange: cover property (@(posedge clk) disable iff (!resetn) over_range_flag && !data_oe_n);
    c_relock: cover property (@(posedge clk) disable iff (!resetn) relock_cnt_r == 7'h01);

endmodule

/* File: capture_model.sv */
// capture_model: far-side capture logic that latches good words off the parallel bus.
// assumes the converter block's clock and words qualified by data_valid.
`timescale 1ns/1ps
module capture_model
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // parallel bus
    input wire logic [9:0] sample_bits,
    input wire logic over_range_flag,
    input wire logic data_oe_n,
    input wire logic data_valid,
    // captured data
    output logic [15:0] word_count,
    output logic [10:0] last_word
);
    // take a word only while driven and marked good; recovery and hi-z words are dropped
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            word_count <= 16'h0000;
            last_word <= 11'h000;
        end
        else if (data_valid && !data_oe_n)
        begin
            word_count <= word_count + 16'h0001;
            last_word <= {over_range_flag, sample_bits};
        end
    end
endmodule

/* File: tb_adc_output_format_power_modes.sv */
// tb_adc_output_format_power_modes: self-checking bench for the converter output block.
// assumes a sample pulse every fourth clock and a short sleep recovery parameter.
`timescale 1ns/1ps
module tb_adc_output_format_power_modes;
    import adc_out_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic sample_en = 1'b0;
    logic run = 1'b1;
    logic [1:0] pace = 2'h0;
    logic signed [RAW_W-1:0] conv_value = '0;
    logic [1:0] format_strap = 2'h0;
    logic out_disable = 1'b0;
    logic power_down_select = 1'b0;
    reg_req_s reg_req = '0;
    logic [31:0] reg_rdata;
    logic [SAMPLE_W-1:0] sample_bits;
    logic over_range_flag, data_oe_n, data_valid, dcs_enable, core_power_down;
    logic ref_power_down, irq;
    logic [15:0] word_count;
    logic [10:0] last_word;
    int err_count = 0;
    int cmp_count = 0;
    int vals[7] = '{0, 1, -1, 511, -512, 600, -700};
    int n0;

    adc_output_ctrl #(.SLEEP_RECOVER_CLKS(120)) u_dut (.clk(clk), .resetn(resetn),
        .sample_en(sample_en), .conv_value(conv_value), .format_strap(format_strap),
        .out_disable(out_disable), .power_down_select(power_down_select),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .sample_bits(sample_bits),
        .over_range_flag(over_range_flag), .data_oe_n(data_oe_n), .data_valid(data_valid),
        .dcs_enable(dcs_enable), .core_power_down(core_power_down),
        .ref_power_down(ref_power_down), .irq(irq));
    capture_model u_cap (.clk(clk), .resetn(resetn), .sample_bits(sample_bits),
        .over_range_flag(over_range_flag), .data_oe_n(data_oe_n), .data_valid(data_valid),
        .word_count(word_count), .last_word(last_word));

    // clock and a steady sample pulse; run lets the bench park the converter
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        pace <= pace + 2'h1;
        sample_en <= run && (pace == 2'h3);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
            err_count++;
        if (got !== exp)
            $display("BAD %0t got %h exp %h", $time, got, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        reg_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge clk);
        reg_req <= '0;
        #1;
        chk(reg_rdata & m, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        reg_req <= '0;
    endtask
    // the strap is only read as reset lifts, so each level needs a fresh reset
    task automatic restart(input logic [1:0] lvl);
        @(posedge clk);
        format_strap <= lvl;
        resetn <= 1'b0;
        cyc(2);
        resetn <= 1'b1;
        cyc(8);
    endtask
    // expected word from the clamp and the format, worked out independently
    function automatic logic [31:0] exp_code(input int v, input logic tw);
        int c;
        c = (v > 511) ? 511 : ((v < -512) ? -512 : v);
        return {21'h00_0000, (v > 511 || v < -512), 10'(c + 512) ^ {tw, 9'h000}};
    endfunction
    task automatic smp(input int v, input logic [31:0] e);
        @(posedge clk);
        conv_value <= v[RAW_W-1:0];
        cyc(9);
        chk({21'h00_0000, over_range_flag, sample_bits}, e);
    endtask
    // bounded wait for a good word; it must not come before lo cycles
    task automatic wait_valid(input int lo, input int hi);
        int n;
        n = 0;
        while (data_valid !== 1'b1 && n < hi)
        begin
            cyc(1);
            n++;
        end
        chk(32'(n >= lo && n < hi), 32'h0000_0001);
    endtask
    task automatic tally_and_finish;
        $display("compares %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        cyc(6);
        rd(REG_CTRL, 32'hffff_ffff, 32'h0000_0000);
        rd(REG_IRQ_MASK, 32'hffff_ffff, 32'h0000_0000);
        rd(8'h10, 32'hffff_ffff, 32'h0000_0000);
        for (int s = 0; s < 4; s++)
        begin
            restart(s[1:0]);
            chk(32'(dcs_enable), 32'(s == 1 || s == 2));
            rd(REG_STATUS, 32'h0000_003f, 32'((s == 1 || s == 2) * 32 + s[1] * 16 + s * 4));
            foreach (vals[i])
                smp(vals[i], exp_code(vals[i], s[1]));
            // park the sample clock past the stop limit; relock must hold data back
            if (s == 1)
            begin
                run <= 1'b0;
                cyc(250);
                run <= 1'b1;
                wait_valid(400, 420);
            end
        end
        restart(2'h0);
        // software override of the strap level, then back to the strap
        wr(REG_CTRL, 32'h0000_0007);
        rd(REG_CTRL, 32'hffff_ffff, 32'h0000_0007);
        rd(REG_STATUS, 32'h0000_003c, 32'h0000_001c);
        smp(0, 32'h0000_0000);
        wr(REG_CTRL, 32'h0000_0000);
        smp(0, 32'h0000_0200);
        n0 = word_count;
        cyc(40);
        chk(32'(word_count - n0), 32'h0000_000a);
        chk(32'(last_word), 32'h0000_0200);
        // disable only across a parked span of the converter
        run <= 1'b0;
        out_disable <= 1'b1;
        cyc(8);
        n0 = word_count;
        chk(32'(data_oe_n), 32'h0000_0001);
        cyc(10);
        chk(32'(word_count - n0), 32'h0000_0000);
        out_disable <= 1'b0;
        run <= 1'b1;
        cyc(8);
        chk(32'(data_oe_n), 32'h0000_0000);
        power_down_select <= 1'b1;
        cyc(8);
        chk({data_oe_n, core_power_down, ref_power_down}, 32'h0000_0006);
        rd(REG_STATUS, 32'h0000_0003, 32'h0000_0001);
        power_down_select <= 1'b0;
        cyc(1);
        wait_valid(400, 420);
        out_disable <= 1'b1;
        power_down_select <= 1'b1;
        cyc(8);
        chk({data_oe_n, core_power_down, ref_power_down}, 32'h0000_0007);
        rd(REG_STATUS, 32'h0000_0003, 32'h0000_0002);
        out_disable <= 1'b0;
        power_down_select <= 1'b0;
        cyc(1);
        wait_valid(120, 140);
        wr(REG_IRQ_STAT, 32'h0000_0007);
        rd(REG_IRQ_STAT, 32'h0000_0007, 32'h0000_0000);
        smp(600, 32'h0000_07ff);
        smp(0, 32'h0000_0200);
        rd(REG_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
        chk(32'(irq), 32'h0000_0000);
        wr(REG_IRQ_MASK, 32'h0000_0001);
        cyc(3);
        chk(32'(irq), 32'h0000_0001);
        wr(REG_IRQ_STAT, 32'h0000_0001);
        cyc(3);
        chk(32'(irq), 32'h0000_0000);
        tally_and_finish;
    end

    // hang guard: an expired limit counts as a mismatch
    initial
    begin
        #500_000;
        err_count++;
        tally_and_finish;
    end
endmodule
